// file: dvo_buzz_model.sv
// Buzzer-side model that measures the pin waveform
`timescale 1ns/10ps
module dvo_buzz_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pin from the device, active low
   input wire logic pin_n,
   // Measured period and low time in clock cycles, and count of falling edges
   output logic [31:0] period,
   output logic [31:0] low_len,
   output logic [31:0] falls
);
   logic [31:0] cnt;
   logic prev;

   // ==========================================================================
   // Measurement
   // Period between falling edges, low time from fall to rise
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 32'h0;
         prev <= 1'b1;
         period <= 32'h0;
         low_len <= 32'h0;
         falls <= 32'h0;
      end else begin
         prev <= pin_n;
         cnt <= cnt + 32'h1;
         if (prev && !pin_n) begin
            period <= cnt;
            falls <= falls + 32'h1;
            cnt <= 32'h1;
         end
         if (!prev && pin_n) begin
            low_len <= cnt;
         end
      end
   end
endmodule

// file: dvo_pkg.sv
// Constants, field layouts and types of the divider square-wave output block
package dvo_pkg;

   // ==========================================================================
   // Register map (byte addresses on APB)
   localparam logic [11:0] DVO_CTRL_OFFSET = 12'h038;
   localparam logic [11:0] DVO_STATUS_OFFSET = 12'h03C;

   // ==========================================================================
   // Control register fields and reset value
   localparam int DVO_EN_BIT = 2;
   localparam int DVO_SEL_HI = 1;
   localparam int DVO_SEL_LO = 0;
   localparam logic [7:0] DVO_CTRL_RESET = 8'h00;

   // ==========================================================================
   // Status register fields
   localparam int DVO_STAT_PIN_BIT = 0;
   localparam int DVO_STAT_LF_BIT = 1;
   localparam int DVO_STAT_DEEP_BIT = 2;

   // ==========================================================================
   // Prescaler widths and tap positions
   localparam int DVO_GEAR_WIDTH = 12;
   localparam int DVO_LF_WIDTH = 5;
   localparam int DVO_GEAR_TAP_BASE = 11;
   localparam int DVO_LF_TAP_BASE = 4;
   localparam logic [DVO_GEAR_WIDTH-1:0] DVO_GEAR_RESET = 12'h000;
   localparam logic [DVO_LF_WIDTH-1:0] DVO_LF_RESET = 5'h00;
   localparam logic [1:0] DVO_SEL_RESERVED = 2'h3;

   // ==========================================================================
   // Types
   typedef struct packed {
      logic en;
      logic [1:0] sel;
   } dvo_ctrl_t;

   localparam dvo_ctrl_t DVO_CTRL_INIT = '{en: 1'b0, sel: 2'h0};

   typedef enum logic [6:0] {
      DVO_MODE_NORMAL = 7'h01,
      DVO_MODE_IDLE = 7'h02,
      DVO_MODE_SLOW = 7'h04,
      DVO_MODE_LIGHT_SLEEP = 7'h08,
      DVO_MODE_STOP = 7'h10,
      DVO_MODE_DEEP_IDLE = 7'h20,
      DVO_MODE_DEEP_SLEEP = 7'h40
   } dvo_mode_t;

endpackage

// file: dvo_sync.sv
// Two-stage synchroniser for one level
`timescale 1ns/10ps
module dvo_sync (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Level in and synchronised level out
   input wire logic din,
   output logic dout
);

   logic meta_reg;

   // First stage feeds only the second stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta_reg <= din;
         dout <= meta_reg;
      end
   end

endmodule

// file: dvo_tb.sv
// Self-checking testbench of the divider square-wave output
`timescale 1ns/10ps
module testbench;
   import dvo_pkg::*;
   typedef struct {
      logic lf;
      dvo_mode_t mode;
      logic [1:0] code;
      logic [31:0] per;
   } dvo_row_t;

   // ==========================================================================
   // Signals
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   dvo_mode_t power_mode = DVO_MODE_NORMAL;
   logic lfsel = 1'b0;
   logic lfclk = 1'b0;
   logic pin_n;
   logic [31:0] period;
   logic [31:0] low_len;
   logic [31:0] falls;
   logic [31:0] rd;
   logic err;
   int miscompares = 0;
   int num_checks = 0;
   // Low-frequency clock is 40 cycles long per period
   dvo_row_t rows[8] = '{
      '{1'b0, DVO_MODE_NORMAL, 2'h0, 32'd4096}, '{1'b0, DVO_MODE_NORMAL, 2'h1, 32'd2048},
      '{1'b0, DVO_MODE_NORMAL, 2'h2, 32'd1024}, '{1'b0, DVO_MODE_IDLE, 2'h3, 32'd512},
      '{1'b1, DVO_MODE_NORMAL, 2'h0, 32'd1280}, '{1'b1, DVO_MODE_IDLE, 2'h1, 32'd640},
      '{1'b0, DVO_MODE_SLOW, 2'h2, 32'd320}, '{1'b0, DVO_MODE_LIGHT_SLEEP, 2'h0, 32'd1280}};
   dvo_mode_t deep[3] = '{DVO_MODE_STOP, DVO_MODE_DEEP_IDLE, DVO_MODE_DEEP_SLEEP};

   // ==========================================================================
   // Clocks, device and far side
   always #2.5 pclk = ~pclk;
   // Slow clock offset by 1.1 ns, its edges at a fixed phase to pclk
   initial begin
      #1.1;
      forever #100 lfclk = ~lfclk;
   end

   dvo_top dvo_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .power_mode(power_mode),
      .low_freq_source_select(lfsel), .low_frequency_clock(lfclk), .buzzer_pin_n(pin_n));

   dvo_buzz_model dvo_buzz_model_i (.clk(pclk), .rst_n(presetn), .pin_n(pin_n),
      .period(period), .low_len(low_len), .falls(falls));

   // ==========================================================================
   // Tasks
   task automatic conclude();
      if (miscompares == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Compare within a tolerance
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
      num_checks++;
      if ((^got === 1'bx) || got + tol < exp || got > exp + tol) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
         input logic [3:0] s);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         miscompares++;
         conclude();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Wait for a number of further falling edges of the pin
   task automatic wait_falls(input int n);
      logic [31:0] s;
      int k;
      s = falls;
      k = 0;
      while (falls < s + n && k < 20000) begin
         @(posedge pclk);
         k++;
      end
      if (k >= 20000) begin
         miscompares++;
         conclude();
      end
   endtask

   // Pin must stay high for n cycles
   task automatic hold_high(input int n);
      int lows;
      lows = 0;
      // Pin is registered: the edge after the change may still show the old level
      @(posedge pclk);
      repeat (n) begin
         @(posedge pclk);
         if (pin_n !== 1'b1) lows++;
      end
      chk(lows, 32'h0, 0);
   endtask

   // ==========================================================================
   // Main sequence
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, DVO_CTRL_OFFSET, 32'h0, 4'hF);
      chk(rd, {24'h0, DVO_CTRL_RESET}, 0);
      chk(pin_n, 32'h1, 0);
      // Table of sources, codes and periods
      foreach (rows[i]) begin
         lfsel <= rows[i].lf;
         power_mode <= rows[i].mode;
         apb(1'b1, DVO_CTRL_OFFSET, {30'h0, rows[i].code}, 4'hF);
         apb(1'b1, DVO_CTRL_OFFSET, {29'h0, 1'b1, rows[i].code}, 4'hF);
         apb(1'b0, DVO_CTRL_OFFSET, 32'h0, 4'hF);
         chk(rd, {29'h0, 1'b1, rows[i].code}, 0);
         wait_falls(3);
         chk(period, rows[i].per, 3);
         chk(low_len, rows[i].per / 2, 3);
      end
      // Register edges and refusals
      lfsel <= 1'b0;
      power_mode <= DVO_MODE_NORMAL;
      apb(1'b1, DVO_CTRL_OFFSET, 32'hFFFF_FFFF, 4'hF);
      apb(1'b0, DVO_CTRL_OFFSET, 32'h0, 4'hF);
      chk(rd, 32'h7, 0);
      apb(1'b1, DVO_CTRL_OFFSET, 32'h0, 4'h0);
      apb(1'b0, DVO_CTRL_OFFSET, 32'h0, 4'hF);
      chk(rd, 32'h7, 0);
      apb(1'b0, 12'h040, 32'h0, 4'hF);
      chk({31'h0, err}, 32'h1, 0);
      chk(rd, 32'h0, 0);
      apb(1'b1, DVO_STATUS_OFFSET, 32'h0, 4'hF);
      chk({31'h0, err}, 32'h1, 0);
      // Software disable holds the pin high
      apb(1'b1, DVO_CTRL_OFFSET, 32'h3, 4'hF);
      hold_high(600);
      // Deep mode entry clears enable and keeps select
      foreach (deep[i]) begin
         power_mode <= DVO_MODE_NORMAL;
         apb(1'b1, DVO_CTRL_OFFSET, 32'h7, 4'hF);
         power_mode <= deep[i];
         apb(1'b0, DVO_CTRL_OFFSET, 32'h0, 4'hF);
         chk(rd, 32'h3, 0);
         apb(1'b0, DVO_STATUS_OFFSET, 32'h0, 4'hF);
         chk(rd & 32'h5, 32'h5, 0);
         hold_high(600);
      end
      // Reserved slow-source code keeps the pin high
      power_mode <= DVO_MODE_NORMAL;
      lfsel <= 1'b1;
      apb(1'b1, DVO_CTRL_OFFSET, 32'h7, 4'hF);
      hold_high(600);
      apb(1'b0, DVO_STATUS_OFFSET, 32'h0, 4'hF);
      chk(rd & 32'h3, 32'h3, 0);
      // Reset in mid-run returns the pin and control to idle
      lfsel <= 1'b0;
      apb(1'b1, DVO_CTRL_OFFSET, 32'h4, 4'hF);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(pin_n, 32'h1, 0);
      presetn <= 1'b1;
      apb(1'b0, DVO_CTRL_OFFSET, 32'h0, 4'hF);
      chk(rd, {24'h0, DVO_CTRL_RESET}, 0);
      conclude();
   end
endmodule

// file: dvo_top.sv
// Divider square-wave output with APB control register
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
module dvo_top
   import dvo_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // System controller status
   input wire dvo_mode_t power_mode,
   input wire logic low_freq_source_select,
   input wire logic low_frequency_clock,
   // Buzzer pin, active low
   output logic buzzer_pin_n
);

   // ==========================================================================
   // Declarations
   dvo_ctrl_t ctrl_reg;
   dvo_ctrl_t ctrl_next;
   logic [DVO_GEAR_WIDTH-1:0] gear_cnt_reg;
   logic [DVO_LF_WIDTH-1:0] lf_cnt_reg;
   logic lf_sync;
   logic lf_prev_reg;
   logic lf_rise;
   logic deep_prev_reg;
   logic in_deep;
   logic deep_entry;
   logic lf_mode;
   logic use_lf;
   logic tap;
   logic tap_valid;
   logic pin_reg;
   logic pin_next;
   logic setup_phase;
   logic access_done;
   logic hit_ctrl;
   logic hit_status;
   logic write_ctrl;
   logic [31:0] rdata_next;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;

   // ==========================================================================
   // Low-frequency clock synchronisation
   // Sampled as a level; rising edges counted in the pclk domain
   dvo_sync u_lf_sync (
      .pclk(pclk),
      .presetn(presetn),
      .din(low_frequency_clock),
      .dout(lf_sync)
   );

   // Edge history, read from the second stage only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lf_prev_reg <= 1'b0;
      end else begin
         lf_prev_reg <= lf_sync;
      end
   end

   assign lf_rise = lf_sync & ~lf_prev_reg;

   // ==========================================================================
   // Free-running prescalers
   // Gear prescaler counts every pclk edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gear_cnt_reg <= DVO_GEAR_RESET;
      end else begin
         gear_cnt_reg <= gear_cnt_reg + 12'h001;
      end
   end

   // Low-frequency prescaler counts synchronised rising edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lf_cnt_reg <= DVO_LF_RESET;
      end else if (lf_rise) begin
         lf_cnt_reg <= lf_cnt_reg + 5'h01;
      end
   end

   // ==========================================================================
   // Operating mode decode
   // Classify the system mode into source and deep-mode flags
   always_comb begin
      in_deep = 1'b0;
      lf_mode = 1'b0;
      unique case (power_mode)
         DVO_MODE_NORMAL, DVO_MODE_IDLE: begin
            lf_mode = 1'b0;
         end
         DVO_MODE_SLOW, DVO_MODE_LIGHT_SLEEP: begin
            lf_mode = 1'b1;
         end
         DVO_MODE_STOP, DVO_MODE_DEEP_IDLE, DVO_MODE_DEEP_SLEEP: begin
            in_deep = 1'b1;
         end
         default: begin
            in_deep = 1'b1;
         end
      endcase
   end

   // Remember deep state to find the entry edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         deep_prev_reg <= 1'b0;
      end else begin
         deep_prev_reg <= in_deep;
      end
   end

   assign deep_entry = in_deep & ~deep_prev_reg;
   assign use_lf = low_freq_source_select | lf_mode;

   // ==========================================================================
   // Tap selection
   // Bit n of a counter toggles every 2^n counts, period 2^(n+1)
   always_comb begin
      tap = 1'b0;
      tap_valid = 1'b1;
      if (use_lf) begin
         if (ctrl_reg.sel == DVO_SEL_RESERVED) begin
            tap_valid = 1'b0;
         end else begin
            tap = lf_cnt_reg[DVO_LF_TAP_BASE - int'(ctrl_reg.sel)];
         end
      end else begin
         tap = gear_cnt_reg[DVO_GEAR_TAP_BASE - int'(ctrl_reg.sel)];
      end
   end

   // ==========================================================================
   // APB decode
   assign setup_phase = psel & ~penable;
   assign access_done = psel & penable & pready_reg;
   assign hit_ctrl = (paddr == DVO_CTRL_OFFSET);
   assign hit_status = (paddr == DVO_STATUS_OFFSET);
   assign write_ctrl = access_done & pwrite & hit_ctrl & pstrb[0];

   // Read data built during setup
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (hit_ctrl) begin
         rdata_next[DVO_EN_BIT] = ctrl_reg.en;
         rdata_next[DVO_SEL_HI:DVO_SEL_LO] = ctrl_reg.sel;
      end else if (hit_status) begin
         rdata_next[DVO_STAT_PIN_BIT] = pin_reg;
         rdata_next[DVO_STAT_LF_BIT] = use_lf;
         rdata_next[DVO_STAT_DEEP_BIT] = in_deep;
      end
   end

   // Answer registered in setup, shown in the single access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= setup_phase;
         if (setup_phase) begin
            pslverr_reg <= ~(hit_ctrl | (hit_status & ~pwrite));
            prdata_reg <= pwrite ? 32'h0000_0000 : rdata_next;
         end else begin
            pslverr_reg <= 1'b0;
         end
      end
   end

   // ==========================================================================
   // Control register
   // Software write, then deep-mode entry forces enable low
   always_comb begin
      ctrl_next = ctrl_reg;
      if (write_ctrl) begin
         ctrl_next.en = pwdata[DVO_EN_BIT];
         ctrl_next.sel = pwdata[DVO_SEL_HI:DVO_SEL_LO];
      end
      if (deep_entry) begin
         ctrl_next.en = 1'b0;
      end
   end

   // Control storage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= DVO_CTRL_INIT;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // ==========================================================================
   // Output pin
   // Inverted tap while enabled, outside deep modes and with a valid tap, high otherwise; cut short on disable
   always_comb begin
      pin_next = 1'b1;
      if (ctrl_reg.en && !in_deep && tap_valid) begin
         pin_next = ~tap;
      end
   end

   // Pin flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_reg <= 1'b1;
      end else begin
         pin_reg <= pin_next;
      end
   end

   // Outputs straight from flops
   assign buzzer_pin_n = pin_reg;
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;

   // ==========================================================================
   // Assertions
   a_pin_idle_high: assert property (
      @(posedge pclk) disable iff (!presetn)
      !ctrl_reg.en |=> pin_reg)
      else $error("pin not high while disabled");

   a_deep_clear_en: assert property (
      @(posedge pclk) disable iff (!presetn)
      deep_entry |=> !ctrl_reg.en ##1 pin_reg)
      else $error("deep entry did not clear enable");

   a_deep_keep_sel: assert property (
      @(posedge pclk) disable iff (!presetn)
      deep_entry && !write_ctrl |=> $stable(ctrl_reg.sel))
      else $error("deep entry changed select");

   a_prescaler_runs: assert property (
      @(posedge pclk) disable iff (!presetn)
      !ctrl_reg.en |=> gear_cnt_reg == $past(gear_cnt_reg) + 12'h001)
      else $error("gear prescaler stalled");

   a_pin_follows_tap: assert property (
      @(posedge pclk) disable iff (!presetn)
      ctrl_reg.en && !in_deep && tap_valid |=> pin_reg == !$past(tap))
      else $error("pin does not follow tap");

   a_gear_tap_sel: assert property (
      @(posedge pclk) disable iff (!presetn)
      !use_lf && ctrl_reg.sel == 2'h0 |-> tap == gear_cnt_reg[11])
      else $error("wrong gear tap");

   a_lf_tap_sel: assert property (
      @(posedge pclk) disable iff (!presetn)
      use_lf && ctrl_reg.sel == 2'h2 |-> tap == lf_cnt_reg[2])
      else $error("wrong low-frequency tap");

   a_lf_reserved_high: assert property (
      @(posedge pclk) disable iff (!presetn)
      use_lf && ctrl_reg.sel == 2'h3 |=> pin_reg)
      else $error("reserved code drove the pin");

   a_lf_count_edge: assert property (
      @(posedge pclk) disable iff (!presetn)
      !lf_rise |=> $stable(lf_cnt_reg))
      else $error("low-frequency count moved without edge");

   a_read_upper_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      setup_phase && hit_ctrl |=> prdata_reg[31:3] == 29'h0)
      else $error("upper control bits not zero");

   a_apb_one_wait: assert property (
      @(posedge pclk) disable iff (!presetn)
      setup_phase |=> pready_reg ##1 !pready_reg)
      else $error("pready timing wrong");

   a_write_takes: assert property (
      @(posedge pclk) disable iff (!presetn)
      write_ctrl && !deep_entry |=> ctrl_reg.en == $past(pwdata[2]))
      else $error("enable write lost");

   a_deep_pin_high: assert property (
      @(posedge pclk) disable iff (!presetn)
      in_deep |=> pin_reg)
      else $error("pin not high in deep mode");

   a_deep_wins_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      deep_entry && write_ctrl |=> !ctrl_reg.en && ctrl_reg.sel == $past(pwdata[1:0]))
      else $error("deep entry lost to software write");

   a_ctrl_holds: assert property (
      @(posedge pclk) disable iff (!presetn)
      !write_ctrl && !deep_entry |=> $stable(ctrl_reg))
      else $error("control changed without write");

   a_strobe_ignored: assert property (
      @(posedge pclk) disable iff (!presetn)
      access_done && pwrite && hit_ctrl && !pstrb[0] && !deep_entry |=> $stable(ctrl_reg))
      else $error("write without strobe landed");

   a_gear_tap_fast: assert property (
      @(posedge pclk) disable iff (!presetn)
      !use_lf && ctrl_reg.sel == 2'h3 |-> tap == gear_cnt_reg[8])
      else $error("wrong fast gear tap");

   a_lf_tap_slow: assert property (
      @(posedge pclk) disable iff (!presetn)
      use_lf && ctrl_reg.sel == 2'h0 |-> tap == lf_cnt_reg[4])
      else $error("wrong slow low-frequency tap");

   a_bad_addr_err: assert property (
      @(posedge pclk) disable iff (!presetn)
      setup_phase && !hit_ctrl && !hit_status |=> pslverr_reg && prdata_reg == 32'h0000_0000)
      else $error("unmapped access not refused");

   a_status_write_err: assert property (
      @(posedge pclk) disable iff (!presetn)
      setup_phase && hit_status && pwrite |=> pslverr_reg)
      else $error("status write not refused");

endmodule
